// >>> logic/humidity_temp_measure_fetch.sv
// bus slave plus measurement sequencer of a humidity/temperature sensor
// assumes scl and sda inputs are already clean and synchronous to clk;
// sensor front end delivers raw codes on hum_raw and temp_raw
//
// Notes on behaviour
// - only a measurement request wakes the sensor from sleep
// - a cycle converts humidity, then temperature, then runs correction
// - results load the output register, then the sensor sleeps again
// - results are 14 bits, sent msb first, big-endian bytes
// - fetch is address with read bit 1; sensor acknowledges it
// - sensor sends bytes until master nacks, then master stops
// - bytes one and two: status in top two bits, humidity below
// - bytes three and four: temperature, lowest two bits undefined
// - status 00 when data not fetched since last finished cycle
// - status 01 when data already fetched since last finished cycle
// - fetch before first cycle completes reports stale status
// - full readable result is four bytes
// - sensor answers only address 44 hex
// - after power-on the sensor sleeps until a request arrives
`timescale 1ns/1ns
module humidity_temp_measure_fetch #(
  parameter int conv_len = sensor_pkg::conv_cycles
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [13:0] hum_raw,
  input wire logic [13:0] temp_raw,
  output logic measuring
);
  // ****************************************
  // bus condition detection
  // ****************************************
  logic scl_q;
  logic sda_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_seen = scl_in & scl_q & ~sda_q & sda_in;

  // ****************************************
  // bus slave state machine
  // ****************************************
  sensor_pkg::bus_state_e bus_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic [1:0] byte_q;
  logic rw_q;
  logic nack_q;
  logic req_q;
  logic fetched_q;
  logic [31:0] out_q;
  logic valid_q;
  logic [7:0] tx_byte;
  logic [1:0] lane;
  logic [1:0] lane_next;

  // past the last byte the word repeats from its start
  assign lane_next = (byte_q == sensor_pkg::result_last_byte)
                     ? 2'h0 : byte_q + 2'h1;
  // in the ack slot the next lane is shown so its msb can go out
  assign lane = (bus_q == sensor_pkg::bus_tx_ack) ? lane_next : byte_q;

  // byte lanes of the output word, status spliced into the first
  always_comb begin
    case (lane)
      2'h0: tx_byte = {(valid_q ? sensor_pkg::stat_fresh
                                : sensor_pkg::stat_stale),
                       out_q[29:24]};
      2'h1: tx_byte = out_q[23:16];
      2'h2: tx_byte = out_q[15:8];
      default: tx_byte = out_q[7:0];
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bus_q <= sensor_pkg::bus_idle;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      byte_q <= 2'h0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      req_q <= 1'b0;
      fetched_q <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      req_q <= 1'b0;
      fetched_q <= 1'b0;
      if (start_seen) begin
        bus_q <= sensor_pkg::bus_addr;
        bit_q <= 4'h0;
        byte_q <= 2'h0;
        sda_oe <= 1'b0;
      end else if (stop_seen) begin
        // request honoured at stop: no data bytes expected
        if (bus_q == sensor_pkg::bus_rx && rw_q == sensor_pkg::dir_write
            && nack_q)
          req_q <= 1'b1;
        bus_q <= sensor_pkg::bus_idle;
        nack_q <= 1'b0;
        sda_oe <= 1'b0;
      end else begin
        case (bus_q)
          sensor_pkg::bus_addr: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_in};
              bit_q <= bit_q + 4'h1;
            end
            if (scl_fall && bit_q == 4'h8) begin
              bit_q <= 4'h0;
              if (shift_q[7:1] == sensor_pkg::dev_addr) begin
                rw_q <= shift_q[0];
                sda_oe <= 1'b1;
                sda_out <= 1'b0;
                bus_q <= sensor_pkg::bus_addr_ack;
              end else begin
                bus_q <= sensor_pkg::bus_ignore;
              end
            end
          end
          sensor_pkg::bus_addr_ack: begin
            if (scl_fall) begin
              byte_q <= 2'h0;
              if (rw_q == sensor_pkg::dir_read) begin
                // open drain: only a zero bit pulls the line
                sda_oe <= ~tx_byte[7];
                bus_q <= sensor_pkg::bus_tx;
              end else begin
                sda_oe <= 1'b0;
                nack_q <= 1'b1;
                bus_q <= sensor_pkg::bus_rx;
              end
            end
          end
          sensor_pkg::bus_tx: begin
            if (scl_fall) begin
              if (bit_q == sensor_pkg::bit_count_max) begin
                bit_q <= 4'h0;
                sda_oe <= 1'b0;
                // status counts as read once its byte has gone out
                if (byte_q == 2'h0)
                  fetched_q <= 1'b1;
                bus_q <= sensor_pkg::bus_tx_ack;
              end else begin
                bit_q <= bit_q + 4'h1;
                sda_oe <= ~tx_byte[3'(4'h6 - bit_q)];
              end
            end
          end
          sensor_pkg::bus_tx_ack: begin
            if (scl_rise)
              nack_q <= sda_in;
            if (scl_fall) begin
              if (nack_q) begin
                bus_q <= sensor_pkg::bus_ignore;
              end else begin
                byte_q <= lane_next;
                sda_oe <= ~tx_byte[7];
                bus_q <= sensor_pkg::bus_tx;
              end
            end
          end
          sensor_pkg::bus_rx: begin
            // a clocked data bit after a write address cancels the
            // request; the stop's own rising clock edge must not
            if (scl_fall) begin
              nack_q <= 1'b0;
              bus_q <= sensor_pkg::bus_ignore;
            end
          end
          default: ;
        endcase
      end
    end
  end
  // ****************************************
  // measurement sequencer
  // ****************************************
  sensor_pkg::meas_state_e meas_q;
  logic [31:0] cnt_q;
  logic [13:0] hum_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      meas_q <= sensor_pkg::meas_sleep;
      cnt_q <= 32'h0;
      hum_q <= 14'h0;
    end else begin
      case (meas_q)
        sensor_pkg::meas_sleep: begin
          cnt_q <= 32'h0;
          if (req_q)
            meas_q <= sensor_pkg::meas_hum;
        end
        sensor_pkg::meas_hum: begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q == 32'(conv_len - 1)) begin
            hum_q <= hum_raw;
            cnt_q <= 32'h0;
            meas_q <= sensor_pkg::meas_temp;
          end
        end
        sensor_pkg::meas_temp: begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q == 32'(conv_len - 1))
            meas_q <= sensor_pkg::meas_dsp;
        end
        default:
          meas_q <= sensor_pkg::meas_sleep;
      endcase
    end
  end
  assign measuring = (meas_q != sensor_pkg::meas_sleep);

  // ****************************************
  // output register and freshness
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      out_q <= 32'h0;
      valid_q <= 1'b0;
    end else if (meas_q == sensor_pkg::meas_dsp) begin
      out_q <= {2'h0, hum_q, temp_raw, 2'h0};
      valid_q <= 1'b1;
    end else if (fetched_q) begin
      valid_q <= 1'b0;
    end
  end
endmodule

// >>> logic/sensor_pkg.sv
// constants for the humidity/temperature sensor bus slave
// assumes a single 100 MHz clock with sda/scl already synchronous
package sensor_pkg;
  localparam logic [6:0] dev_addr = 7'h44;
  localparam logic dir_write = 1'b0;
  localparam logic dir_read = 1'b1;
  localparam logic [1:0] stat_fresh = 2'h0;
  localparam logic [1:0] stat_stale = 2'h1;
  localparam int result_bits = 14;
  localparam int result_bytes = 4;
  localparam logic [1:0] result_last_byte = 2'h3;
  localparam logic [3:0] bit_count_max = 4'h7;
  localparam int conv_time_ns = 10000;
  localparam int clk_period_ns = 10;
  localparam int conv_cycles = conv_time_ns / clk_period_ns;
  typedef enum logic [3:0] {
    bus_idle = 4'h0,
    bus_addr = 4'h1,
    bus_addr_ack = 4'h3,
    bus_tx = 4'h2,
    bus_tx_ack = 4'h6,
    bus_rx = 4'h7,
    bus_rx_ack = 4'h5,
    bus_ignore = 4'h4
  } bus_state_e;
  typedef enum logic [1:0] {
    meas_sleep = 2'h0,
    meas_hum = 2'h1,
    meas_temp = 2'h3,
    meas_dsp = 2'h2
  } meas_state_e;
endpackage

// >>> verification/sensor_asserts.sv
// port checker for the sensor bus slave and its sequencer
// assumes it is bound to the top module with its conv_len
`timescale 1ns/1ns
module sensor_asserts #(
  parameter int conv_len = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [13:0] hum_raw,
  input wire logic [13:0] temp_raw,
  input wire logic measuring
);
  localparam int meas_max = 2 * conv_len + 40;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence scl_high_held;
    scl_in ##1 scl_in;
  endsequence
  sequence bus_released;
    scl_in && sda_in;
  endsequence
  reset_quiet_a: assert property ($fell(reset) |-> !sda_oe && !measuring)
    else $error("slave busy right after reset");
  drive_low_a: assert property (sda_oe |-> !sda_out)
    else $error("driven data level not low");
  oe_rise_low_a: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data driven while clock high");
  oe_fall_low_a: assert property ($fell(sda_oe) |-> !scl_in)
    else $error("data released while clock high");
  oe_hold_a: assert property (scl_high_held |-> $stable(sda_oe))
    else $error("data moved while clock high");
  meas_end_a: assert property ($rose(measuring) |-> ##[1:meas_max] !measuring)
    else $error("measurement never finished");
  meas_len_a: assert property ($rose(measuring) |-> measuring[*8])
    else $error("measurement cycle too short");
  wake_idle_a: assert property ($rose(measuring) |-> bus_released)
    else $error("measurement began with bus busy");
endmodule

// >>> verification/bus_master_model.sv
// bus master model: start, stop and byte transfers on scl/sda
// assumes the bench resolves sda from both open-drain drivers
`timescale 1ns/1ns
module bus_master_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_m
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // data moves only with scl low, sampled mid high phase
  task automatic bit_x(input logic b, output logic r);
    sda_m <= b;
    tick(4);
    scl <= 1'b1;
    tick(2);
    r = sda;
    tick(2);
    scl <= 1'b0;
  endtask
  task automatic start();
    sda_m <= 1'b0;
    tick(4);
    scl <= 1'b0;
  endtask
  task automatic stop();
    sda_m <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda_m <= 1'b1;
    tick(8);
  endtask
  // ack_in 1 releases sda: used for writes and the final nack
  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] r, output logic ack_out);
    for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
    bit_x(ack_in, ack_out);
  endtask
endmodule

// >>> verification/humidity_temp_measure_fetch_tb.sv
// self-checking bench for the sensor slave with a shortened conversion
// assumes the master model drives scl and the released-high sda
`timescale 1ns/1ns
module humidity_temp_measure_fetch_tb;
  logic clk, reset, ack, sda_out, sda_oe, measuring;
  logic [13:0] hum_raw, temp_raw;
  logic [7:0] rd;
  logic [7:0] got [4];
  int error_cnt, num_checks;
  wire scl, sda_m, sda;
  assign sda = sda_m & ~sda_oe;
  humidity_temp_measure_fetch #(.conv_len(4)) dut (.clk(clk),
    .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .hum_raw(hum_raw), .temp_raw(temp_raw),
    .measuring(measuring));
  bus_master_model m (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic fail(input string s);
    error_cnt++;
    $display("unexpected at %0t: %s", $time, s);
  endtask
  task automatic check_byte(input logic [7:0] a, e);
    num_checks++;
    if (a !== e) fail($sformatf("byte %h, wanted %h", a, e));
  endtask
  task automatic check_bit(input logic a, e);
    num_checks++;
    if (a !== e) fail("flag level wrong");
  endtask
  task automatic addr(input logic [6:0] a, input logic dir);
    m.start();
    m.xfer({a, dir}, 1'b1, rd, ack);
  endtask
  // master nacks the last byte it wants, then stops
  task automatic fetch(input int n);
    addr(sensor_pkg::dev_addr, sensor_pkg::dir_read);
    check_bit(ack, 1'b0);
    check_bit(sda_out, 1'b0);
    for (int i = 0; i < n; i++) m.xfer(8'hff, i == n - 1, got[i], ack);
    // after the nack the slave must not start the next byte
    repeat (2) @(posedge clk);
    check_bit(sda_oe, 1'b0);
    m.stop();
  endtask
  task automatic wait_meas(input logic v);
    for (int n = 0; n < 300 && measuring !== v; n++) @(posedge clk);
    check_bit(measuring, v);
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    fail("watchdog expired");
    complete_run();
  end
  task automatic test_early_fetch();
    fetch(2);
    check_byte(got[0] & 8'hc0, 8'h40);
    check_bit(measuring, 1'b0);
    $display("early fetch done");
  endtask
  task automatic test_foreign_addr();
    addr(7'h45, sensor_pkg::dir_write);
    m.stop();
    check_bit(ack, 1'b1);
    check_bit(measuring, 1'b0);
    $display("foreign address done");
  endtask
  // a write address followed by a data byte is no request
  task automatic test_write_data();
    addr(sensor_pkg::dev_addr, sensor_pkg::dir_write);
    check_bit(ack, 1'b0);
    m.xfer(8'h00, 1'b1, rd, ack);
    m.stop();
    check_bit(measuring, 1'b0);
    $display("write with data done");
  endtask
  task automatic test_measure();
    addr(sensor_pkg::dev_addr, sensor_pkg::dir_write);
    check_bit(ack, 1'b0);
    m.stop();
    wait_meas(1'b1);
    wait_meas(1'b0);
    fetch(4);
    check_byte(got[0], {2'h0, hum_raw[13:8]});
    check_byte(got[1], hum_raw[7:0]);
    check_byte(got[2], temp_raw[13:6]);
    check_byte(got[3] & 8'hfc, {temp_raw[5:0], 2'h0});
    $display("measure and fetch done");
  endtask
  task automatic test_stale();
    fetch(2);
    check_byte(got[0], {2'h1, hum_raw[13:8]});
    check_byte(got[1], hum_raw[7:0]);
    check_bit(sda_oe, 1'b0);
    $display("second fetch done");
  endtask
  initial begin
    reset = 1'b1;
    hum_raw = 14'h2a5c;
    temp_raw = 14'h1337;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    test_early_fetch();
    test_foreign_addr();
    test_write_data();
    test_measure();
    test_stale();
    complete_run();
  end
endmodule
bind humidity_temp_measure_fetch sensor_asserts #(.conv_len(conv_len)) chk (
  .clk(clk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .hum_raw(hum_raw),
  .temp_raw(temp_raw), .measuring(measuring));
